/* File: shared/pps_pkg.sv */
package pps_pkg;
	// Clock rate and derived tick for the safety timer
	localparam int unsigned CLK_HZ          = 250_000_000;
	localparam int unsigned TICK_US         = 1000;
	localparam int unsigned TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned TICK_W          = 18;
	// Safety timer limits in seconds, counted in millisecond ticks
	localparam int unsigned LIM_ADULT_S     = 128;
	localparam int unsigned LIM_NEO_MID_S   = 90;
	localparam int unsigned LIM_NEO_SHORT_S = 60;
	localparam int unsigned MS_PER_S        = 1000;
	localparam int unsigned MS_W            = 18;
	// Timer limit selection codes
	localparam logic [1:0]  LIM_SEL_ADULT   = 2'h0;
	localparam logic [1:0]  LIM_SEL_NEO90   = 2'h1;
	localparam logic [1:0]  LIM_SEL_NEO60   = 2'h2;
	// Panel scanning
	localparam int unsigned NUM_KEYS        = 8;
	localparam int unsigned KEY_IDX_W       = 3;
	localparam int unsigned KEY_CODE_W      = 8;
	localparam logic [3:0]  CODE_PRESS      = 4'h1;
	localparam logic [3:0]  CODE_RELEASE    = 4'h2;
	localparam logic [3:0]  CODE_KNOB_CW    = 4'h3;
	localparam logic [3:0]  CODE_KNOB_CCW   = 4'h4;
	// Valve PWM, tone generator and ADC widths
	localparam int unsigned PWM_W           = 8;
	localparam int unsigned TONE_W          = 16;
	localparam int unsigned ADC_W           = 12;
	// Battery chemistry
	localparam logic        CHEM_LEAD       = 1'b0;
	localparam logic        CHEM_LITHIUM    = 1'b1;
	localparam logic [1:0]  LVL_OFF         = 2'h0;
	localparam logic [1:0]  LVL_LEAD        = 2'h1;
	localparam logic [1:0]  LVL_LITHIUM     = 2'h2;
	typedef enum logic [1:0] {PPS_OFF, PPS_ON} pps_pwr_t;
endpackage

/* File: core/pps_pwm.sv */
`timescale 1ns/1ps
// Free-running duty-cycle generator for one manifold valve
module pps_pwm (
	input  wire logic                       ref_clk,
	input  wire logic                       rst,
	input  wire logic                       run,
	input  wire logic [pps_pkg::PWM_W-1:0]  duty,
	output logic                            pwm_out
);
	logic [pps_pkg::PWM_W-1:0] cnt_ff;
	logic [pps_pkg::PWM_W-1:0] nxt_cnt;
	logic                      out_ff;
	logic                      nxt_out;

	// Counter wraps; output high while count is below duty
	always_comb
	begin
		nxt_cnt = run ? cnt_ff + {{(pps_pkg::PWM_W-1){1'b0}}, 1'b1}
			: '0;
		nxt_out = run && (cnt_ff < duty);
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			cnt_ff <= '0;
			out_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			out_ff <= nxt_out;
		end
	end

	assign pwm_out = out_ff;
endmodule

/* File: core/pps_supervisor.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - A press of the local or remote power button toggles both logic supplies.
// - The charger flyback supply runs while mains is present or unit is on.
// - Key and knob events are encoded and handed to the main processor.
// - Valve modulation runs only while the main processor commands it.
// - A safety timer starts when the pump or second valve turns on.
// - At the limit a fault is flagged and manifold 12V feed is removed.
// - Charging starts when needed and ends when the battery is full.
// - Battery chemistry is detected and sets the charge level.
// - Battery voltage and current are sampled continuously.
// - Recorder power follows the main processor's request while the unit is on.
// - The audio base tone frequency follows the processor's selection.
module pps_supervisor (
	input  wire logic                              ref_clk,
	input  wire logic                              rst,
	input  wire logic                              pwr_btn_local,
	input  wire logic                              pwr_btn_remote,
	input  wire logic                              mains_present,
	output logic                                   supply_3v3_en,
	output logic                                   supply_5v_en,
	output logic                                   flyback_en,
	input  wire logic [pps_pkg::NUM_KEYS-1:0]      keys,
	input  wire logic                              knob_a,
	input  wire logic                              knob_b,
	output logic                                   key_valid,
	output logic [pps_pkg::KEY_CODE_W-1:0]         key_code,
	input  wire logic                              key_ready,
	input  wire logic                              valve_mod_en,
	input  wire logic [pps_pkg::PWM_W-1:0]         valve1_duty,
	input  wire logic [pps_pkg::PWM_W-1:0]         second_manifold_valve_duty,
	output logic                                   valve1_pwm,
	output logic                                   second_manifold_valve_pwm,
	input  wire logic                              pump_on,
	input  wire logic                              second_manifold_valve_on,
	input  wire logic [1:0]                        limit_sel,
	input  wire logic                              fault_clear,
	output logic                                   cuff_pressure_measurement_fault,
	output logic                                   manifold_12v_en,
	input  wire logic                              batt_low,
	input  wire logic                              batt_full,
	input  wire logic                              batt_chem_sense,
	output logic                                   charge_en,
	output logic [1:0]                             charge_level,
	output logic                                   batt_is_lithium,
	input  wire logic [pps_pkg::ADC_W-1:0]         batt_v_adc,
	input  wire logic [pps_pkg::ADC_W-1:0]         batt_i_adc,
	output logic [pps_pkg::ADC_W-1:0]              batt_v,
	output logic [pps_pkg::ADC_W-1:0]              batt_i,
	input  wire logic                              recorder_req,
	output logic                                   recorder_pwr_en,
	input  wire logic [pps_pkg::TONE_W-1:0]        tone_half_period,
	output logic                                   tone_out
);
	// Power state and button edge
	pps_pkg::pps_pwr_t pwr_ff;
	pps_pkg::pps_pwr_t nxt_pwr;
	logic              btn_ff;
	logic              nxt_btn;
	logic              btn_now;

	assign btn_now = pwr_btn_local | pwr_btn_remote;

	always_comb
	begin
		nxt_btn = btn_now;
		nxt_pwr = pwr_ff;
		if (btn_now && !btn_ff)
			nxt_pwr = (pwr_ff == pps_pkg::PPS_ON) ? pps_pkg::PPS_OFF
				: pps_pkg::PPS_ON;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pwr_ff <= pps_pkg::PPS_OFF;
			btn_ff <= 1'b0;
		end
		else
		begin
			pwr_ff <= nxt_pwr;
			btn_ff <= nxt_btn;
		end
	end

	// Both rails switch together so the processor sees one clean power-up
	assign supply_3v3_en = (pwr_ff == pps_pkg::PPS_ON);
	assign supply_5v_en  = (pwr_ff == pps_pkg::PPS_ON);
	assign flyback_en    = mains_present | (pwr_ff == pps_pkg::PPS_ON);

	// Key scan: previous state per key, lowest changed key reported first
	logic [pps_pkg::NUM_KEYS-1:0]   key_prev_ff;
	logic [pps_pkg::NUM_KEYS-1:0]   nxt_key_prev;
	logic                           kv_ff;
	logic                           nxt_kv;
	logic [pps_pkg::KEY_CODE_W-1:0] kc_ff;
	logic [pps_pkg::KEY_CODE_W-1:0] nxt_kc;
	logic                           ka_ff;
	logic                           nxt_ka;
	logic [pps_pkg::NUM_KEYS-1:0]   key_chg;

	// Change mask built one bit per key
	genvar gi;
	generate
		for (gi = 0; gi < pps_pkg::NUM_KEYS; gi++)
		begin : g_chg
			assign key_chg[gi] = keys[gi] ^ key_prev_ff[gi];
		end
	endgenerate

	// One event held at a time; others wait since prev state is not updated
	always_comb
	begin
		nxt_key_prev = key_prev_ff;
		nxt_kv       = kv_ff;
		nxt_kc       = kc_ff;
		nxt_ka       = knob_a;
		if (kv_ff && key_ready)
			nxt_kv = 1'b0;
		if (!kv_ff || key_ready)
		begin
			if (knob_a && !ka_ff)
			begin
				nxt_kv = 1'b1;
				nxt_kc = {knob_b ? pps_pkg::CODE_KNOB_CCW
					: pps_pkg::CODE_KNOB_CW, 4'h0};
			end
			else
			begin
				for (int i = pps_pkg::NUM_KEYS - 1; i >= 0; i--)
				begin
					if (key_chg[i])
					begin
						nxt_kv = 1'b1;
						nxt_kc = {keys[i] ? pps_pkg::CODE_PRESS
							: pps_pkg::CODE_RELEASE, 1'b0,
							i[pps_pkg::KEY_IDX_W-1:0]};
					end
				end
				for (int i = 0; i < pps_pkg::NUM_KEYS; i++)
				begin
					if (key_chg[i] && !(knob_a && !ka_ff) &&
						((key_chg & ((8'h01 << i) - 8'h01)) == 8'h00))
						nxt_key_prev[i] = keys[i];
				end
			end
		end
		// A knob edge that must wait is dropped; knob is rate-limited
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			key_prev_ff <= '0;
			kv_ff       <= 1'b0;
			kc_ff       <= '0;
			ka_ff       <= 1'b0;
		end
		else
		begin
			key_prev_ff <= nxt_key_prev;
			kv_ff       <= nxt_kv;
			kc_ff       <= nxt_kc;
			ka_ff       <= nxt_ka;
		end
	end

	assign key_valid = kv_ff;
	assign key_code  = kc_ff;

	// Valve modulation gated by the processor's command
	pps_pwm u_pwm1 (
		.ref_clk (ref_clk),
		.rst     (rst),
		.run     (valve_mod_en),
		.duty    (valve1_duty),
		.pwm_out (valve1_pwm)
	);

	pps_pwm u_pwm2 (
		.ref_clk (ref_clk),
		.rst     (rst),
		.run     (valve_mod_en),
		.duty    (second_manifold_valve_duty),
		.pwm_out (second_manifold_valve_pwm)
	);

	// Safety timer in millisecond ticks
	localparam logic [pps_pkg::MS_W-1:0] LIM_A =
		pps_pkg::MS_W'(pps_pkg::LIM_ADULT_S * pps_pkg::MS_PER_S);
	localparam logic [pps_pkg::MS_W-1:0] LIM_90 =
		pps_pkg::MS_W'(pps_pkg::LIM_NEO_MID_S * pps_pkg::MS_PER_S);
	localparam logic [pps_pkg::MS_W-1:0] LIM_60 =
		pps_pkg::MS_W'(pps_pkg::LIM_NEO_SHORT_S * pps_pkg::MS_PER_S);
	localparam logic [pps_pkg::TICK_W-1:0] TICK_LAST =
		pps_pkg::TICK_W'(pps_pkg::TICK_CYC - 1);

	logic [pps_pkg::TICK_W-1:0] tick_ff;
	logic [pps_pkg::TICK_W-1:0] nxt_tick;
	logic [pps_pkg::MS_W-1:0]   ms_ff;
	logic [pps_pkg::MS_W-1:0]   nxt_ms;
	logic                       flt_ff;
	logic                       nxt_flt;
	logic [pps_pkg::MS_W-1:0]   limit;
	logic                       active;

	assign active = pump_on | second_manifold_valve_on;

	always_comb
	begin
		unique case (limit_sel)
			pps_pkg::LIM_SEL_NEO90: limit = LIM_90;
			pps_pkg::LIM_SEL_NEO60: limit = LIM_60;
			default:                limit = LIM_A; // Unused code: safest is adult
		endcase
		nxt_tick = tick_ff;
		nxt_ms   = ms_ff;
		nxt_flt  = flt_ff;
		if (!active)
		begin
			nxt_tick = '0;
			nxt_ms   = '0;
		end
		else if (ms_ff < limit)
		begin
			if (tick_ff == TICK_LAST)
			begin
				nxt_tick = '0;
				nxt_ms   = ms_ff + {{(pps_pkg::MS_W-1){1'b0}}, 1'b1};
			end
			else
				nxt_tick = tick_ff + {{(pps_pkg::TICK_W-1){1'b0}}, 1'b1};
		end
		// Fault latches; the clear acts only while pump and second valve are off, so it never meets a timeout
		if (fault_clear && !active)
			nxt_flt = 1'b0;
		if (active && ms_ff >= limit)
			nxt_flt = 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			tick_ff <= '0;
			ms_ff   <= '0;
			flt_ff  <= 1'b0;
		end
		else
		begin
			tick_ff <= nxt_tick;
			ms_ff   <= nxt_ms;
			flt_ff  <= nxt_flt;
		end
	end

	assign cuff_pressure_measurement_fault = flt_ff;
	assign manifold_12v_en                 = !flt_ff;

	// Charger control, chemistry and measurements
	logic                       chg_ff;
	logic                       nxt_chg;
	logic                       chem_ff;
	logic [pps_pkg::ADC_W-1:0]  bv_ff;
	logic [pps_pkg::ADC_W-1:0]  bi_ff;

	always_comb
	begin
		nxt_chg = chg_ff;
		if (batt_low && !batt_full)
			nxt_chg = 1'b1;
		else if (batt_full)
			nxt_chg = 1'b0;
		if (!flyback_en)
			nxt_chg = 1'b0; // No source to charge from
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			chg_ff  <= 1'b0;
			chem_ff <= pps_pkg::CHEM_LEAD;
			bv_ff   <= '0;
			bi_ff   <= '0;
		end
		else
		begin
			chg_ff  <= nxt_chg;
			chem_ff <= batt_chem_sense;
			bv_ff   <= batt_v_adc;
			bi_ff   <= batt_i_adc;
		end
	end

	assign charge_en       = chg_ff;
	assign batt_is_lithium = (chem_ff == pps_pkg::CHEM_LITHIUM);
	assign charge_level    = !chg_ff ? pps_pkg::LVL_OFF
		: (chem_ff == pps_pkg::CHEM_LITHIUM) ? pps_pkg::LVL_LITHIUM
		: pps_pkg::LVL_LEAD;
	assign batt_v          = bv_ff;
	assign batt_i          = bi_ff;

	// Recorder power and tone square wave
	logic                       rec_ff;
	logic [pps_pkg::TONE_W-1:0] tcnt_ff;
	logic [pps_pkg::TONE_W-1:0] nxt_tcnt;
	logic                       tone_ff;
	logic                       nxt_tone;

	// Zero half period silences the tone
	always_comb
	begin
		nxt_tcnt = tcnt_ff + {{(pps_pkg::TONE_W-1){1'b0}}, 1'b1};
		nxt_tone = tone_ff;
		if (tone_half_period == '0)
		begin
			nxt_tcnt = '0;
			nxt_tone = 1'b0;
		end
		else if (tcnt_ff >= tone_half_period - 16'h0001)
		begin
			nxt_tcnt = '0;
			nxt_tone = !tone_ff;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			rec_ff  <= 1'b0;
			tcnt_ff <= '0;
			tone_ff <= 1'b0;
		end
		else
		begin
			rec_ff  <= recorder_req && (pwr_ff == pps_pkg::PPS_ON);
			tcnt_ff <= nxt_tcnt;
			tone_ff <= nxt_tone;
		end
	end

	assign recorder_pwr_en = rec_ff;
	assign tone_out        = tone_ff;
endmodule

/* File: verification/pps_supervisor_chk.sv */
`timescale 1ns/1ps
// Watches the supervisor's pins only
module pps_supervisor_chk (
	input wire logic                        ref_clk,
	input wire logic                        rst,
	input wire logic                        pwr_btn_local,
	input wire logic                        pwr_btn_remote,
	input wire logic                        mains_present,
	input wire logic                        supply_3v3_en,
	input wire logic                        supply_5v_en,
	input wire logic                        flyback_en,
	input wire logic                        key_valid,
	input wire logic [pps_pkg::KEY_CODE_W-1:0] key_code,
	input wire logic                        key_ready,
	input wire logic                        valve_mod_en,
	input wire logic                        valve1_pwm,
	input wire logic                        second_manifold_valve_pwm,
	input wire logic                        pump_on,
	input wire logic                        second_manifold_valve_on,
	input wire logic                        fault_clear,
	input wire logic                        cuff_pressure_measurement_fault,
	input wire logic                        manifold_12v_en,
	input wire logic                        batt_full,
	input wire logic                        charge_en,
	input wire logic [1:0]                  charge_level,
	input wire logic                        batt_is_lithium,
	input wire logic [pps_pkg::ADC_W-1:0]   batt_v_adc,
	input wire logic [pps_pkg::ADC_W-1:0]   batt_v,
	input wire logic                        recorder_req,
	input wire logic                        recorder_pwr_en
);
	// One clock domain, so one default clock and reset
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	pwr_toggle_a: assert property ($rose(pwr_btn_local | pwr_btn_remote) |=>
		supply_3v3_en != $past(supply_3v3_en)) else $error("power did not toggle");
	rails_pair_a: assert property (supply_3v3_en == supply_5v_en)
		else $error("logic rails differ");
	flyback_on_a: assert property (flyback_en == (mains_present | supply_3v3_en))
		else $error("flyback enable wrong");
	key_hold_a: assert property (key_valid && !key_ready |=>
		key_valid && $stable(key_code)) else $error("key code dropped early");
	valve_idle_a: assert property (!valve_mod_en [*3] |->
		!valve1_pwm && !second_manifold_valve_pwm) else $error("valve moves uncommanded");
	fault_cause_a: assert property ($rose(cuff_pressure_measurement_fault) |->
		$past(pump_on | second_manifold_valve_on)) else $error("fault without timer");
	feed_cut_a: assert property (manifold_12v_en == !cuff_pressure_measurement_fault)
		else $error("manifold feed mismatch");
	timer_clear_a: assert property (!(pump_on | second_manifold_valve_on) && fault_clear
		|=> !cuff_pressure_measurement_fault) else $error("fault not cleared");
	charge_stop_a: assert property (batt_full |=> !charge_en)
		else $error("charging past full");
	charge_level_a: assert property (charge_level ==
		(charge_en ? (batt_is_lithium ? 2'h2 : 2'h1) : 2'h0)) else $error("level wrong");
	volt_sample_a: assert property (batt_v == $past(batt_v_adc))
		else $error("voltage not sampled");
	rec_off_a: assert property (!recorder_req |=> !recorder_pwr_en)
		else $error("recorder powered unasked");
endmodule

bind pps_supervisor pps_supervisor_chk pps_supervisor_chk_inst (.*);

/* File: verification/pps_host_model.sv */
`timescale 1ns/1ps
// Host side of the key channel; slow mode stalls every other cycle
module pps_host_model (
	input  wire logic                         ref_clk,
	input  wire logic                         rst,
	input  wire logic                         slow,
	input  wire logic                         key_valid,
	input  wire logic [pps_pkg::KEY_CODE_W-1:0] key_code,
	output logic                              key_ready,
	output logic                              got,
	output logic [pps_pkg::KEY_CODE_W-1:0]    got_code
);
	// Ready toggles when slow so a code must wait for the host
	always_ff @(posedge ref_clk)
		if (rst)
		begin
			key_ready <= 1'b0;
			got       <= 1'b0;
			got_code  <= 8'h00;
		end
		else
		begin
			key_ready <= slow ? ~key_ready : 1'b1;
			got       <= key_valid & key_ready;
			got_code  <= key_code;
		end
endmodule

/* File: verification/pps_supervisor_tb.sv */
`timescale 1ns/1ps
module pps_supervisor_tb;
	logic        ref_clk = 1'b0, rst = 1'b1, slow = 1'b1, got;
	logic        pwr_btn_local = 1'b0, pwr_btn_remote = 1'b0, mains_present = 1'b0;
	logic        knob_a = 1'b0, knob_b = 1'b0, valve_mod_en = 1'b0, pump_on = 1'b0;
	logic        second_manifold_valve_on = 1'b0, fault_clear = 1'b0;
	logic        batt_low = 1'b0, batt_full = 1'b0, batt_chem_sense = 1'b0;
	logic        recorder_req = 1'b0;
	logic [7:0]  keys = 8'h00, valve1_duty = 8'h00, second_manifold_valve_duty = 8'h00;
	logic [1:0]  limit_sel = 2'h0, charge_level;
	logic [11:0] batt_v_adc = 12'h000, batt_i_adc = 12'h000, batt_v, batt_i;
	logic [15:0] tone_half_period = 16'h0000;
	logic [7:0]  key_code, got_code, exp_q[$];
	logic        supply_3v3_en, supply_5v_en, flyback_en, key_valid, key_ready;
	logic        valve1_pwm, second_manifold_valve_pwm, manifold_12v_en, tone_out;
	logic        cuff_pressure_measurement_fault, charge_en, batt_is_lithium;
	logic        recorder_pwr_en, prev;
	int          fail_count = 0, n_tests = 0, seed = 9, pwr = 0, i, k, h1, h2, d1, d2;

	// 250 MHz
	always #2 ref_clk = ~ref_clk;

	pps_supervisor pps_supervisor_inst (.*);
	pps_host_model pps_host_model_inst (.ref_clk(ref_clk), .rst(rst), .slow(slow),
		.key_valid(key_valid), .key_code(key_code), .key_ready(key_ready),
		.got(got), .got_code(got_code));

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Waits past the edge so its updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic press(input int remote);
		@(posedge ref_clk);
		pwr_btn_remote <= remote[0];
		pwr_btn_local <= !remote[0];
		cyc(3);
		@(posedge ref_clk);
		pwr_btn_remote <= 1'b0;
		pwr_btn_local <= 1'b0;
		cyc(3);
		pwr ^= 1;
	endtask

	task automatic summarize;
		$display("checks=%0d mismatches=%0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Each accepted code must match the oldest expected event
	always @(posedge ref_clk)
		if (got === 1'b1)
			chk(16'(got_code), 16'(exp_q.pop_front()));

	// Whole run is under two thousand cycles; far beyond that is a hang
	initial
	begin
		#100000;
		fail_count++;
		summarize();
	end

	initial
	begin
		cyc(2);
		rst <= 1'b0;
		cyc(1);
		chk(16'(flyback_en), 16'h0000);
		chk(16'(manifold_12v_en), 16'h0001);
		@(posedge ref_clk);
		mains_present <= 1'b1;
		cyc(1);
		chk(16'(flyback_en), 16'h0001);
		@(posedge ref_clk);
		mains_present <= 1'b0;
		// Odd count of presses, both buttons, leaves the unit on
		for (i = 0; i < 5; i++)
		begin
			press(i);
			chk(16'(supply_3v3_en), 16'(pwr));
			chk(16'(supply_5v_en), 16'(pwr));
			chk(16'(flyback_en), 16'(pwr));
		end
		// Key press and release, then both knob directions
		for (i = 0; i < 6; i++)
		begin
			k = $random(seed) & 7;
			@(posedge ref_clk);
			slow <= i[0];
			if (i < 4)
				keys[k] <= ~keys[k];
			else
				knob_b <= i[0];
			if (i < 4)
				exp_q.push_back(8'(keys[k] ? 8'h20 + k : 8'h10 + k));
			else
				exp_q.push_back(i[0] ? 8'h40 : 8'h30);
			@(posedge ref_clk);
			knob_a <= (i >= 4);
			cyc(20);
			@(posedge ref_clk);
			knob_a <= 1'b0;
			if (i < 4)
				keys[k] <= 1'b0;
			if (i < 4 && keys[k])
				exp_q.push_back(8'(8'h20 + k));
			cyc(20);
		end
		chk(16'(exp_q.size()), 16'h0000);
		d1 = $random(seed) & 255;
		d2 = $random(seed) & 255;
		@(posedge ref_clk);
		valve1_duty <= 8'(d1);
		second_manifold_valve_duty <= 8'(d2);
		valve_mod_en <= 1'b1;
		cyc(300);
		h1 = 0;
		h2 = 0;
		repeat (512)
		begin
			cyc(1);
			h1 += valve1_pwm;
			h2 += second_manifold_valve_pwm;
		end
		chk(16'(h1), 16'(2 * d1));
		chk(16'(h2), 16'(2 * d2));
		d1 = 10 + ($random(seed) & 7);
		@(posedge ref_clk);
		valve_mod_en <= 1'b0;
		tone_half_period <= 16'(d1);
		cyc(3 * d1);
		h1 = 0;
		prev = tone_out;
		repeat (20 * d1)
		begin
			cyc(1);
			h1 += (tone_out !== prev);
			prev = tone_out;
		end
		chk(16'(h1), 16'd20);
		// Both chemistries: level follows the fitted type
		for (i = 0; i < 4; i++)
		begin
			@(posedge ref_clk);
			batt_chem_sense <= i[0];
			batt_full <= 1'b0;
			batt_low <= 1'b1;
			batt_v_adc <= 12'($random(seed));
			batt_i_adc <= 12'($random(seed));
			cyc(3);
			chk(16'(charge_en), 16'h0001);
			chk(16'(charge_level), i[0] ? 16'h0002 : 16'h0001);
			chk(16'(batt_is_lithium), 16'(i[0]));
			chk(16'(batt_v), 16'(batt_v_adc));
			chk(16'(batt_i), 16'(batt_i_adc));
			@(posedge ref_clk);
			batt_full <= 1'b1;
			batt_low <= 1'b0;
			recorder_req <= i[1];
			cyc(3);
			chk(16'(charge_en), 16'h0000);
			chk(16'(recorder_pwr_en), 16'(i[1]));
		end
		@(posedge ref_clk);
		limit_sel <= pps_pkg::LIM_SEL_NEO60;
		pump_on <= 1'b1;
		second_manifold_valve_on <= 1'b1;
		cyc(200);
		chk(16'(cuff_pressure_measurement_fault), 16'h0000);
		@(posedge ref_clk);
		pump_on <= 1'b0;
		second_manifold_valve_on <= 1'b0;
		fault_clear <= 1'b1;
		cyc(2);
		chk(16'(manifold_12v_en), 16'h0001);
		summarize();
	end
endmodule
